// ### sim/bipadc_host_model.sv
/*
  Host end of the link: chip select, serial clock and command data out,
  result word in. Assumes the output enable says whether data is driven.
*/
`timescale 1ns/1ns
`default_nettype none

module bipadc_host_model (
  // pacing clock
  input  wire logic i_sys_clk,
  // device data pin
  input  wire logic i_dout,
  input  wire logic i_dout_oe,
  // host pins
  output var logic  o_cs_n,
  output var logic  o_sclk,
  output var logic  o_din
);
  logic line;

  initial begin
    o_cs_n = 1'b1;
    o_sclk = 1'b1;
    o_din  = 1'b0;
    line   = 1'b0;
  end

  // half serial period is four system cycles; an undriven line reads as
  // the opposite of its last level so a float never passes for data
  task automatic frame(input logic [15:0] cmd, input int n_fall,
                       output logic [15:0] rx);
    rx = 16'h0000;
    o_cs_n = 1'b0;
    o_din = cmd[15];
    repeat (8) @(negedge i_sys_clk);
    for (int i = 0; i < n_fall; i++) begin
      line = i_dout_oe ? i_dout : ~line;
      rx[15-i] = line;
      o_sclk = 1'b0;
      repeat (4) @(negedge i_sys_clk);
      o_sclk = 1'b1;
      if (i < 15) o_din = cmd[14-i];
      repeat (4) @(negedge i_sys_clk);
    end
    o_cs_n = 1'b1;
    o_din = ~o_din;
    repeat (8) @(negedge i_sys_clk);
  endtask
endmodule // bipadc_host_model

`default_nettype wire

// ### sim/bipadc_serial_port_sva.sv
/*
  Checker for the serial port: frame start, return to track, loads,
  end-of-frame drive, aborts and idle drive.
  Assumes the serial clock stays below a quarter of the system clock.
*/
`timescale 1ns/1ns
`default_nettype none

module bipadc_serial_port_sva #(
  parameter int CTRL_W = bipadc_pkg::CTRL_W
) (
  // clock and reset
  input  wire logic              i_sys_clk,
  input  wire logic              i_rst,
  // host pins
  input  wire logic              i_cs_n,
  input  wire logic              i_sclk,
  input  wire logic              o_dout_oe,
  input  wire logic              o_dout_weak,
  // converter control and registers
  input  wire logic              o_hold,
  input  wire logic              o_conv_start,
  input  wire logic              o_abort,
  input  wire logic              o_frame_done,
  input  wire logic [CTRL_W-1:0] o_ctrl,
  input  wire logic              o_reg_written
);
  logic       sclk_q;
  logic [4:0] rise_cnt;
  logic [4:0] fall_cnt;

  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);

  // raw pin edges lead the design's view by its synchroniser depth
  always_ff @(posedge i_sys_clk) begin
    sclk_q <= i_rst ? 1'b1 : i_sclk;
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst || o_conv_start) begin
      rise_cnt <= 5'h00;
      fall_cnt <= 5'h00;
    end else begin
      if (i_sclk && !sclk_q) rise_cnt <= rise_cnt + 5'h01;
      if (!i_sclk && sclk_q) fall_cnt <= fall_cnt + 5'h01;
    end
  end

  sequence s_quiet;
    (i_cs_n && !o_ctrl[bipadc_pkg::CTRL_WEAK_BIT])[*8];
  endsequence
  sequence s_weak_drive;
    o_dout_oe && o_dout_weak;
  endsequence

  property p_start;
    $rose(o_hold) |-> o_conv_start && o_dout_oe && !o_dout_weak;
  endproperty
  property p_cause;
    o_conv_start |-> $past(i_cs_n, 3) == 1'b0;
  endproperty
  property p_track;
    $fell(o_hold) && !i_cs_n |-> rise_cnt == 5'h0E;
  endproperty
  property p_done;
    o_frame_done |-> fall_cnt == 5'h10;
  endproperty
  property p_float;
    o_frame_done && !o_ctrl[bipadc_pkg::CTRL_WEAK_BIT] |-> ##[0:1] !o_dout_oe;
  endproperty
  property p_weak;
    o_frame_done && o_ctrl[bipadc_pkg::CTRL_WEAK_BIT] |-> ##[0:1] s_weak_drive;
  endproperty
  property p_abort;
    o_abort |-> i_cs_n ##[0:1] (!o_hold && (!o_dout_oe || o_dout_weak));
  endproperty
  property p_idle;
    s_quiet |-> !o_dout_oe;
  endproperty
  property p_load;
    o_reg_written |-> fall_cnt == 5'h0B || rise_cnt == 5'h0F;
  endproperty

  a_start: assert property (p_start) else $error("hold without start");
  a_cause: assert property (p_cause) else $error("start without cs");
  a_track: assert property (p_track) else $error("track edge wrong");
  a_done: assert property (p_done) else $error("frame length wrong");
  a_float: assert property (p_float) else $error("no float at end");
  a_weak: assert property (p_weak) else $error("no weak drive");
  a_abort: assert property (p_abort) else $error("abort drive wrong");
  a_idle: assert property (p_idle) else $error("driven while idle");
  a_load: assert property (p_load) else $error("load edge wrong");
endmodule // bipadc_serial_port_sva

bind bipadc_serial_port bipadc_serial_port_sva #(.CTRL_W(CTRL_W)) u_sva (
  .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_cs_n(i_cs_n), .i_sclk(i_sclk),
  .o_dout_oe(o_dout_oe), .o_dout_weak(o_dout_weak), .o_hold(o_hold),
  .o_conv_start(o_conv_start), .o_abort(o_abort),
  .o_frame_done(o_frame_done), .o_ctrl(o_ctrl),
  .o_reg_written(o_reg_written));

`default_nettype wire

// ### sim/bipadc_serial_port_test.sv
/*
  Bench for the serial port: host frames, results through the buffer,
  register loads, aborts and idle drive.
  Assumes the checker binds itself from its own file.
*/
`timescale 1ns/1ns
`default_nettype none

module bipadc_serial_port_test;
  localparam logic [15:0] W_A = 16'hA5C3;
  localparam logic [15:0] W_B = 16'hC3E7;
  localparam logic [15:0] W_C = 16'h5E2D;
  logic        i_sys_clk = 1'b0;
  logic        i_rst     = 1'b1;
  logic        cs_n, sclk, din, dout, dout_oe, dout_weak;
  logic        res_valid = 1'b0;
  logic [15:0] res_data  = 16'h0000;
  logic        res_ready;
  logic [11:0] ctrl;
  logic [6:0]  seq, range_lo, range_hi;
  logic [15:0] rx;
  logic        tick, under;
  int          n_tick     = 0;
  int          n_under    = 0;
  int          n_fail     = 0;
  int          num_checks = 0;

  always #10 i_sys_clk = ~i_sys_clk;

  bipadc_serial_port dut (
    .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_cs_n(cs_n), .i_sclk(sclk),
    .i_din(din), .o_dout(dout), .o_dout_oe(dout_oe),
    .o_dout_weak(dout_weak), .i_res_valid(res_valid),
    .i_res_data(res_data), .o_res_ready(res_ready), .o_hold(),
    .o_conv_start(), .o_conv_tick(tick), .o_abort(), .o_frame_done(),
    .o_underrun(under), .o_ctrl(ctrl), .o_seq(seq), .o_range_lo(range_lo),
    .o_range_hi(range_hi), .o_reg_written());

  bipadc_host_model host (
    .i_sys_clk(i_sys_clk), .i_dout(dout), .i_dout_oe(dout_oe),
    .o_cs_n(cs_n), .o_sclk(sclk), .o_din(din));

  // one-cycle pulses are counted at the falling edge, where they stand
  always @(negedge i_sys_clk) begin
    if (tick === 1'b1) n_tick++;
    if (under === 1'b1) n_under++;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // ready is read at the falling edge, where it has settled
  task automatic push(input logic [15:0] w);
    @(negedge i_sys_clk);
    res_valid = 1'b1;
    res_data  = w;
    while (res_ready !== 1'b1) @(negedge i_sys_clk);
    @(negedge i_sys_clk);
    res_valid = 1'b0;
  endtask

  task automatic t_fill();
    chk({4'h0, ctrl}, 16'h0000);
    chk({14'h0, dout_oe, res_ready}, 16'h0001);
    push(W_A);
    push(W_B);
    chk({15'h0, res_ready}, 16'h0000);
    $display("test fill done");
  endtask

  task automatic t_ctrl();
    host.frame({3'h0, 1'b1, 12'hA35}, 16, rx);
    chk(rx, W_A);
    chk({4'h0, ctrl}, 16'h0A34);
    chk({13'h0, dout_oe, dout_weak, dout}, {13'h0, 2'b11, W_B[15]});
    $display("test ctrl done");
  endtask

  task automatic t_short();
    logic [6:0] v [1:3];
    v[1] = 7'h5A;
    v[2] = 7'h33;
    v[3] = 7'h6C;
    for (int s = 1; s <= 3; s++) begin
      host.frame({s[2:0], 1'b1, v[s], 5'h15}, 16, rx);
      chk(rx, W_B);
    end
    chk(n_under[15:0], 16'h0002);
    chk({9'h000, range_lo}, {9'h000, v[1]});
    chk({9'h000, range_hi}, {9'h000, v[2]});
    chk({9'h000, seq}, {9'h000, v[3]});
    host.frame({3'h1, 1'b0, 7'h7F, 5'h00}, 16, rx);
    host.frame({3'h5, 1'b1, 7'h7F, 5'h00}, 16, rx);
    chk({9'h000, range_lo}, {9'h000, v[1]});
    chk({9'h000, seq}, {9'h000, v[3]});
    chk({4'h0, ctrl}, 16'h0A34);
    $display("test short done");
  endtask

  task automatic t_abort();
    n_tick = 0;
    host.frame({3'h1, 1'b1, 7'h01, 5'h00}, 9, rx);
    chk({9'h000, range_lo}, 16'h005A);
    chk(n_tick[15:0], 16'h0009);
    chk({14'h0, dout_oe, dout_weak}, 16'h0003);
    host.frame({3'h3, 1'b1, 7'h11, 5'h00}, 12, rx);
    chk({9'h000, seq}, 16'h0011);
    host.frame({3'h0, 1'b1, 12'h001}, 14, rx);
    chk({4'h0, ctrl}, 16'h0A34);
    $display("test abort done");
  endtask

  task automatic t_float();
    push(W_C);
    host.frame({3'h0, 1'b1, 12'h3C1}, 16, rx);
    chk(rx, W_C);
    chk({4'h0, ctrl}, 16'h03C0);
    chk({14'h0, dout_oe, dout_weak}, 16'h0000);
    repeat (20) @(negedge i_sys_clk);
    chk({15'h0, dout_oe}, 16'h0000);
    $display("test float done");
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial begin
    repeat (16) @(negedge i_sys_clk);
    i_rst = 1'b0;
    repeat (4) @(negedge i_sys_clk);
    t_fill();
    t_ctrl();
    t_short();
    t_abort();
    t_float();
    close_out();
  end

  // ten frames of at most 144 cycles each, with ample margin
  initial begin
    repeat (6000) @(posedge i_sys_clk);
    n_fail++;
    $display("Error at %0t: timeout", $time);
    close_out();
  end
endmodule // bipadc_serial_port_test

`default_nettype wire

// ### src/bipadc_pair_buf.sv
/*
  Two-entry buffer with valid and ready on both sides.
  Assumes one clock and a synchronous active-high reset; read data come
  straight from the entry registers.
*/
`timescale 1ns/1ns
`default_nettype none

module bipadc_pair_buf #(
  parameter int W = 16
) (
  // clock and reset
  input  wire logic         i_sys_clk,
  input  wire logic         i_rst,
  // filling side
  input  wire logic         i_valid,
  input  wire logic [W-1:0] i_data,
  output logic              o_ready,
  // draining side
  output logic              o_valid,
  output logic [W-1:0]      o_data,
  input  wire logic         i_ready
);

  logic [W-1:0] entry [2];
  logic         wr_ptr;
  logic         rd_ptr;
  logic [1:0]   count;
  logic         push;
  logic         pop;

  assign o_ready = (count != 2'h2);
  assign o_valid = (count != 2'h0);
  assign o_data  = entry[rd_ptr];
  assign push    = i_valid & o_ready;
  assign pop     = o_valid & i_ready;

  always_ff @(posedge i_sys_clk) begin
    if (push) begin
      entry[wr_ptr] <= i_data;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      count  <= 2'h0;
    end else begin
      if (push) begin
        wr_ptr <= ~wr_ptr;
      end
      if (pop) begin
        rd_ptr <= ~rd_ptr;
      end
      if (push && !pop) begin
        count <= count + 2'h1;
      end else if (pop && !push) begin
        count <= count - 2'h1;
      end
    end
  end

endmodule // bipadc_pair_buf

`default_nettype wire

// ### src/bipadc_pkg.sv
/*
  Shared constants of the bipolar converter serial port: frame length,
  edge numbers at which things happen, command word layout, register
  select codes and reset values.
  Assumes a 16-clock frame, most significant bit first in both directions.
*/
package bipadc_pkg;

  // frame shape
  localparam int WORD_W          = 16;
  localparam int SEL_W           = 3;
  localparam int CTRL_W          = 12;
  localparam int SHORT_W         = 7;
  localparam int CNT_W           = 5;

  // edge numbers inside one frame, counted from 1
  localparam logic [4:0] HOLD_END_RISE   = 5'h0E;
  localparam logic [4:0] CTRL_LOAD_RISE  = 5'h0F;
  localparam logic [4:0] SHORT_LOAD_FALL = 5'h0B;
  localparam logic [4:0] LAST_FALL       = 5'h10;

  // command word layout, bit numbers within the received shift register
  // at the moment of the load edge
  localparam int CTRL_SEL_LSB    = 12;
  localparam int CTRL_WR_BIT     = 11;
  localparam int SHORT_SEL_LSB   = 8;
  localparam int SHORT_WR_BIT    = 7;

  // register select codes
  localparam logic [2:0] SEL_CTRL     = 3'h0;
  localparam logic [2:0] SEL_RANGE_LO = 3'h1;
  localparam logic [2:0] SEL_RANGE_HI = 3'h2;
  localparam logic [2:0] SEL_SEQ      = 3'h3;

  // control register field
  localparam int CTRL_WEAK_BIT   = 2;

  // reset values
  localparam logic [11:0] CTRL_RST   = 12'h000;
  localparam logic [6:0]  SHORT_RST  = 7'h00;
  localparam logic [15:0] WORD_RST   = 16'h0000;
  // synchroniser idle levels: chip select and serial clock idle high
  localparam logic [2:0]  PIN_RST    = 3'h3;

endpackage

// ### src/bipadc_serial_port.sv
/*
  Device end of the serial port of an eight-channel sign-plus-12-bit
  converter: frame control, command reception, register loads, result
  shifting and the idle drive of the data output.
  Assumes the host's chip select, serial clock and data line arrive
  unsynchronised; the serial clock must be well below a quarter of
  i_sys_clk. Results come from the converter core as a valid/ready stream.
*/
`timescale 1ns/1ns
`default_nettype none

module bipadc_serial_port #(
  parameter int WORD_W  = bipadc_pkg::WORD_W,
  parameter int CTRL_W  = bipadc_pkg::CTRL_W,
  parameter int SHORT_W = bipadc_pkg::SHORT_W
) (
  // clock and reset
  input  wire logic              i_sys_clk,
  input  wire logic              i_rst,
  // host pins
  input  wire logic              i_cs_n,
  input  wire logic              i_sclk,
  input  wire logic              i_din,
  output logic                   o_dout,
  output logic                   o_dout_oe,
  output logic                   o_dout_weak,
  // results from the converter core
  input  wire logic              i_res_valid,
  input  wire logic [WORD_W-1:0] i_res_data,
  output logic                   o_res_ready,
  // converter control
  output logic                   o_hold,
  output logic                   o_conv_start,
  output logic                   o_conv_tick,
  output logic                   o_abort,
  output logic                   o_frame_done,
  output logic                   o_underrun,
  // register contents
  output logic [CTRL_W-1:0]      o_ctrl,
  output logic [SHORT_W-1:0]     o_seq,
  output logic [SHORT_W-1:0]     o_range_lo,
  output logic [SHORT_W-1:0]     o_range_hi,
  output logic                   o_reg_written
);

  typedef enum logic [2:0] {
    BIPADC_IDLE  = 3'b001,
    BIPADC_SHIFT = 3'b010,
    BIPADC_DONE  = 3'b100
  } bipadc_state_t;

  bipadc_state_t state;

  // three-stage synchronisers: bit 0 chip select, 1 serial clock, 2 data
  logic [2:0] sync_a;
  logic [2:0] sync_b;
  logic [2:0] sync_c;
  logic [1:0] pin_lvl;

  logic cs_fall;
  logic cs_rise;
  logic sclk_fall;
  logic sclk_rise;
  logic din_bit;

  logic [4:0]        fall_cnt;
  logic [4:0]        rise_cnt;
  logic [4:0]        next_fall;
  logic [4:0]        next_rise;
  logic [WORD_W-1:0] rx_sr;
  logic [WORD_W-1:0] next_rx;
  logic [WORD_W-1:0] tx_sr;
  logic [WORD_W-1:0] last_word;

  // buffer draining side
  logic              buf_valid;
  logic [WORD_W-1:0] buf_data;
  logic              buf_take;

  logic              frame_start;
  logic              weak_on;
  logic              next_tag_msb;
  logic [2:0]        short_sel;
  logic              short_wr;
  logic [2:0]        ctrl_sel;
  logic              ctrl_wr;

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      sync_a <= bipadc_pkg::PIN_RST;
      sync_b <= bipadc_pkg::PIN_RST;
      sync_c <= bipadc_pkg::PIN_RST;
      pin_lvl <= bipadc_pkg::PIN_RST[1:0];
    end else begin
      sync_a <= {i_din, i_sclk, i_cs_n};
      sync_b <= sync_a;
      sync_c <= sync_b;
      // a new level is taken only where two stages agree, not on one sample
      pin_lvl <= (sync_b[1:0] & sync_c[1:0]) |
                 (pin_lvl & (sync_b[1:0] ^ sync_c[1:0]));
    end
  end

  // an edge counts once the second and third stages agree on a new level
  assign cs_fall   = pin_lvl[0] & ~sync_b[0] & ~sync_c[0];
  assign cs_rise   = ~pin_lvl[0] & sync_b[0] & sync_c[0];
  assign sclk_fall = pin_lvl[1] & ~sync_b[1] & ~sync_c[1];
  assign sclk_rise = ~pin_lvl[1] & sync_b[1] & sync_c[1];
  assign din_bit   = sync_c[2];

  assign frame_start  = (state == BIPADC_IDLE) & cs_fall;
  assign buf_take     = frame_start & buf_valid;
  assign weak_on      = o_ctrl[bipadc_pkg::CTRL_WEAK_BIT];
  assign next_tag_msb = buf_valid ? buf_data[WORD_W-1]
                                  : last_word[WORD_W-1];

  assign next_fall = fall_cnt + 5'h01;
  assign next_rise = rise_cnt + 5'h01;
  assign next_rx   = {rx_sr[WORD_W-2:0], din_bit};

  // command fields as they stand when the relevant load edge arrives
  assign short_sel = next_rx[bipadc_pkg::SHORT_SEL_LSB +: 3];
  assign short_wr  = next_rx[bipadc_pkg::SHORT_WR_BIT];
  assign ctrl_sel  = rx_sr[bipadc_pkg::CTRL_SEL_LSB +: 3];
  assign ctrl_wr   = rx_sr[bipadc_pkg::CTRL_WR_BIT];

  // results wait here so that a slow host frame rate loses no word
  bipadc_pair_buf #(
    .W (WORD_W)
  ) u_res_buf (
    .i_sys_clk (i_sys_clk),
    .i_rst     (i_rst),
    .i_valid   (i_res_valid),
    .i_data    (i_res_data),
    .o_ready   (o_res_ready),
    .o_valid   (buf_valid),
    .o_data    (buf_data),
    .i_ready   (buf_take)
  );

  // frame sequencing
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      state <= BIPADC_IDLE;
    end else begin
      case (state)
        BIPADC_IDLE: begin
          if (cs_fall) begin
            state <= BIPADC_SHIFT;
          end
        end
        BIPADC_SHIFT: begin
          if (cs_rise) begin
            state <= BIPADC_IDLE;
          end else if (sclk_fall && next_fall == bipadc_pkg::LAST_FALL) begin
            state <= BIPADC_DONE;
          end
        end
        BIPADC_DONE: begin
          if (cs_rise) begin
            state <= BIPADC_IDLE;
          end
        end
        default: begin
          state <= BIPADC_IDLE;
        end
      endcase
    end
  end

  // edge counters, paced only by the host serial clock
  always_ff @(posedge i_sys_clk) begin
    if (i_rst || frame_start) begin
      fall_cnt <= 5'h00;
      rise_cnt <= 5'h00;
    end else if (state == BIPADC_SHIFT) begin
      if (sclk_fall) begin
        fall_cnt <= next_fall;
      end
      if (sclk_rise) begin
        rise_cnt <= next_rise;
      end
    end
  end

  // command reception
  always_ff @(posedge i_sys_clk) begin
    if (i_rst || frame_start) begin
      rx_sr <= bipadc_pkg::WORD_RST;
    end else if (state == BIPADC_SHIFT && sclk_fall) begin
      rx_sr <= next_rx;
    end
  end

  // result shifting; the first tag bit is up right after chip select falls
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      tx_sr     <= bipadc_pkg::WORD_RST;
      last_word <= bipadc_pkg::WORD_RST;
    end else if (frame_start) begin
      if (buf_valid) begin
        tx_sr     <= buf_data;
        last_word <= buf_data;
      end else begin
        tx_sr <= last_word;
      end
    end else if (state == BIPADC_SHIFT && sclk_fall) begin
      tx_sr <= {tx_sr[WORD_W-2:0], 1'b0};
    end
  end

  // data output pin
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_dout      <= 1'b0;
      o_dout_oe   <= 1'b0;
      o_dout_weak <= 1'b0;
    end else if (frame_start) begin
      o_dout      <= buf_valid ? buf_data[WORD_W-1]
                               : last_word[WORD_W-1];
      o_dout_oe   <= 1'b1;
      o_dout_weak <= 1'b0;
    end else if (state == BIPADC_SHIFT && !cs_rise &&
                 !(sclk_fall && next_fall == bipadc_pkg::LAST_FALL)) begin
      o_dout      <= tx_sr[WORD_W-1];
      o_dout_oe   <= 1'b1;
      o_dout_weak <= 1'b0;
      if (sclk_fall) begin
        o_dout <= tx_sr[WORD_W-2];
      end
    end else if (weak_on) begin
      // a weak driver that any pull resistor overrides
      o_dout      <= next_tag_msb;
      o_dout_oe   <= 1'b1;
      o_dout_weak <= 1'b1;
    end else begin
      o_dout      <= 1'b0;
      o_dout_oe   <= 1'b0;
      o_dout_weak <= 1'b0;
    end
  end

  // sampler hold and conversion pacing
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_hold       <= 1'b0;
      o_conv_start <= 1'b0;
      o_conv_tick  <= 1'b0;
      o_abort      <= 1'b0;
      o_frame_done <= 1'b0;
      o_underrun   <= 1'b0;
    end else begin
      o_conv_start <= frame_start;
      o_underrun   <= frame_start & ~buf_valid;
      o_conv_tick  <= (state == BIPADC_SHIFT) & sclk_rise;
      o_abort      <= (state == BIPADC_SHIFT) & cs_rise;
      o_frame_done <= (state == BIPADC_SHIFT) & ~cs_rise & sclk_fall &
                      (next_fall == bipadc_pkg::LAST_FALL);
      if (frame_start) begin
        o_hold <= 1'b1;
      end else if (state == BIPADC_SHIFT && cs_rise) begin
        o_hold <= 1'b0;
      end else if (state == BIPADC_SHIFT && sclk_rise &&
                   next_rise == bipadc_pkg::HOLD_END_RISE) begin
        o_hold <= 1'b0;
      end
    end
  end

  // control register: eleven received bits land in the upper bits, the
  // lowest bit arrives only after the load edge and loads as zero
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_ctrl <= bipadc_pkg::CTRL_RST;
    end else if (state == BIPADC_SHIFT && !cs_rise && sclk_rise &&
                 next_rise == bipadc_pkg::CTRL_LOAD_RISE &&
                 ctrl_sel == bipadc_pkg::SEL_CTRL && ctrl_wr) begin
      o_ctrl <= {rx_sr[CTRL_W-2:0], 1'b0};
    end
  end

  // sequence and range registers
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_seq      <= bipadc_pkg::SHORT_RST;
      o_range_lo <= bipadc_pkg::SHORT_RST;
      o_range_hi <= bipadc_pkg::SHORT_RST;
    end else if (state == BIPADC_SHIFT && !cs_rise && sclk_fall &&
                 next_fall == bipadc_pkg::SHORT_LOAD_FALL && short_wr) begin
      if (short_sel == bipadc_pkg::SEL_SEQ) begin
        o_seq <= next_rx[SHORT_W-1:0];
      end else if (short_sel == bipadc_pkg::SEL_RANGE_LO) begin
        o_range_lo <= next_rx[SHORT_W-1:0];
      end else if (short_sel == bipadc_pkg::SEL_RANGE_HI) begin
        o_range_hi <= next_rx[SHORT_W-1:0];
      end
    end
  end

  // one pulse for any register load, for the converter core
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_reg_written <= 1'b0;
    end else begin
      o_reg_written <=
        (state == BIPADC_SHIFT) & ~cs_rise &
        ((sclk_rise & (next_rise == bipadc_pkg::CTRL_LOAD_RISE) &
          (ctrl_sel == bipadc_pkg::SEL_CTRL) & ctrl_wr) |
         (sclk_fall & (next_fall == bipadc_pkg::SHORT_LOAD_FALL) & short_wr &
          ((short_sel == bipadc_pkg::SEL_SEQ) ||
           (short_sel == bipadc_pkg::SEL_RANGE_LO) ||
           (short_sel == bipadc_pkg::SEL_RANGE_HI))));
    end
  end

endmodule // bipadc_serial_port

`default_nettype wire
